// ---- p2m_pkg.sv ----
// Package for the shared-pin port block: register map, field positions,
// reset values and the carrier structs used on the pin side.
// Assumes a single clock domain and the plain strobe register port.
package p2m_pkg;
   localparam int         P2M_ADDR_W        = 3;
   localparam int         P2M_DATA_W        = 8;

   // Register offsets
   localparam logic [2:0] P2M_OFF_PIN_MODE  = 3'h0;
   localparam logic [2:0] P2M_OFF_DIR1      = 3'h1;
   localparam logic [2:0] P2M_OFF_DATA1     = 3'h2;
   localparam logic [2:0] P2M_OFF_DIR2      = 3'h3;
   localparam logic [2:0] P2M_OFF_DATA2     = 3'h4;

   // Pin mode register fields
   localparam int         P2M_PM_IRQ_LSB    = 4;
   localparam int         P2M_PM_TX_BIT     = 1;
   localparam int         P2M_PM_TIMER_BIT  = 0;
   localparam logic [7:0] P2M_PM_WMASK      = 8'hF3;
   localparam logic [7:0] P2M_PM_ONES       = 8'h0C;

   // Port 1 layout: pins 7..4 interrupt capable, pin 3 absent, pin 0 timer
   localparam logic [7:0] P2M_P1_MASK       = 8'hF7;
   localparam logic [7:0] P2M_P1_ONES       = 8'h08;
   localparam int         P2M_P1_IRQ_LSB    = 4;
   localparam int         P2M_P1_TIMER_PIN  = 0;

   // Port 2 layout
   localparam int         P2M_P2_TX_PIN     = 2;
   localparam int         P2M_P2_RX_PIN     = 1;
   localparam int         P2M_P2_CLK_PIN    = 0;
   localparam logic [4:0] P2M_P2_ONES       = 5'h1F;

   // Reset values and fixed answers
   localparam logic [7:0] P2M_RST_BYTE      = 8'h00;
   localparam logic [2:0] P2M_RST_P2        = 3'h0;
   localparam logic [7:0] P2M_WO_READ       = 8'hFF;
   localparam logic [7:0] P2M_UNMAPPED_READ = 8'h00;

   // Control bits owned by the serial unit
   typedef struct packed {
      logic rx_enable;
      logic ext_clk_sel;
      logic int_clk_out_sel;
      logic sync_mode;
   } p2m_serial_ctrl_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
   } p2m_pad1_t;

   typedef struct packed {
      logic [2:0] out;
      logic [2:0] oe_n;
   } p2m_pad2_t;
endpackage

// ---- p2m_port_mux.sv ----
// Two general I/O ports whose pins are shared with a serial unit,
// interrupt inputs and a timer output.
// Assumes pin inputs synchronous to clk and a master that never waits.
`timescale 1ns/100ps
module p2m_port_mux
(
   input  wire logic                      clk,
   input  wire logic                      reset,
   input  wire logic [2:0]                addr,
   input  wire logic [7:0]                wdata,
   input  wire logic                      wr,
   input  wire logic                      rd,
   output logic      [7:0]                rdata,
   input  wire logic [7:0]                p1_in,
   output p2m_pkg::p2m_pad1_t             p1_pad,
   input  wire logic [2:0]                p2_in,
   output p2m_pkg::p2m_pad2_t             p2_pad,
   input  wire p2m_pkg::p2m_serial_ctrl_t serial_ctrl,
   input  wire logic                      serial_tx_data,
   input  wire logic                      serial_clk_out,
   output logic                           serial_rx_data,
   output logic                           serial_clk_in,
   input  wire logic                      timer_wave_output,
   output logic      [3:0]                irq_level_n
);
   logic [7:0]         pin_mode_select_reg;
   logic [7:0]         dir1;
   logic [7:0]         data1;
   logic [2:0]         port_direction_control;
   logic [2:0]         port_output_data;
   logic [7:0]         next_rdata;
   p2m_pkg::p2m_pad1_t next_p1_pad;
   p2m_pkg::p2m_pad2_t next_p2_pad;
   logic               tx_sel;
   logic               clk_drive;

   assign tx_sel    = pin_mode_select_reg[p2m_pkg::P2M_PM_TX_BIT];
   assign clk_drive = serial_ctrl.int_clk_out_sel | serial_ctrl.sync_mode;

   // Register writes
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pin_mode_select_reg    <= p2m_pkg::P2M_RST_BYTE;
         dir1                   <= p2m_pkg::P2M_RST_BYTE;
         data1                  <= p2m_pkg::P2M_RST_BYTE;
         port_direction_control <= p2m_pkg::P2M_RST_P2;
         port_output_data       <= p2m_pkg::P2M_RST_P2;
      end
      else if (wr)
      begin
         case (addr)
            p2m_pkg::P2M_OFF_PIN_MODE:
               pin_mode_select_reg <= wdata & p2m_pkg::P2M_PM_WMASK;
            p2m_pkg::P2M_OFF_DIR1:
               dir1 <= wdata & p2m_pkg::P2M_P1_MASK;
            p2m_pkg::P2M_OFF_DATA1:
               data1 <= wdata & p2m_pkg::P2M_P1_MASK;
            p2m_pkg::P2M_OFF_DIR2:
               port_direction_control <= wdata[2:0];
            p2m_pkg::P2M_OFF_DATA2:
               port_output_data <= wdata[2:0];
            default:
               ;
         endcase
      end
   end

   // Read mux; direction registers are write-only and read as all ones
   always_comb
   begin
      next_rdata = p2m_pkg::P2M_UNMAPPED_READ;
      case (addr)
         p2m_pkg::P2M_OFF_PIN_MODE:
            next_rdata = pin_mode_select_reg | p2m_pkg::P2M_PM_ONES;
         p2m_pkg::P2M_OFF_DIR1:
            next_rdata = p2m_pkg::P2M_WO_READ;
         p2m_pkg::P2M_OFF_DATA1:
            next_rdata = (((dir1 & data1) | (~dir1 & p1_in)) & p2m_pkg::P2M_P1_MASK)
                         | p2m_pkg::P2M_P1_ONES;
         p2m_pkg::P2M_OFF_DIR2:
            next_rdata = p2m_pkg::P2M_WO_READ;
         p2m_pkg::P2M_OFF_DATA2:
            next_rdata = {p2m_pkg::P2M_P2_ONES,
                          (port_direction_control & port_output_data)
                          | (~port_direction_control & p2_in)};
         default:
            next_rdata = p2m_pkg::P2M_UNMAPPED_READ;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (reset)
         rdata <= p2m_pkg::P2M_RST_BYTE;
      else if (rd)
         rdata <= next_rdata;
      else
         rdata <= p2m_pkg::P2M_RST_BYTE;
   end

   // Port 2 pin function selection
   always_comb
   begin
      next_p2_pad.out  = port_output_data;
      next_p2_pad.oe_n = ~port_direction_control;
      if (tx_sel)
      begin
         next_p2_pad.out[p2m_pkg::P2M_P2_TX_PIN]  = serial_tx_data;
         next_p2_pad.oe_n[p2m_pkg::P2M_P2_TX_PIN] = 1'b0;
      end
      if (serial_ctrl.rx_enable)
      begin
         next_p2_pad.out[p2m_pkg::P2M_P2_RX_PIN]  = 1'b0;
         next_p2_pad.oe_n[p2m_pkg::P2M_P2_RX_PIN] = 1'b1;
      end
      if (serial_ctrl.ext_clk_sel)
      begin
         next_p2_pad.out[p2m_pkg::P2M_P2_CLK_PIN]  = 1'b0;
         next_p2_pad.oe_n[p2m_pkg::P2M_P2_CLK_PIN] = 1'b1;
      end
      else if (clk_drive)
      begin
         next_p2_pad.out[p2m_pkg::P2M_P2_CLK_PIN]  = serial_clk_out;
         next_p2_pad.oe_n[p2m_pkg::P2M_P2_CLK_PIN] = 1'b0;
      end
   end

   // Port 1 pin function selection; the absent pin never drives
   always_comb
   begin
      next_p1_pad.out  = data1;
      next_p1_pad.oe_n = ~dir1;
      for (int k = 0; k < 4; k++)
      begin
         if (pin_mode_select_reg[p2m_pkg::P2M_PM_IRQ_LSB + k])
         begin
            next_p1_pad.out[p2m_pkg::P2M_P1_IRQ_LSB + k]  = 1'b0;
            next_p1_pad.oe_n[p2m_pkg::P2M_P1_IRQ_LSB + k] = 1'b1;
         end
      end
      if (pin_mode_select_reg[p2m_pkg::P2M_PM_TIMER_BIT])
      begin
         next_p1_pad.out[p2m_pkg::P2M_P1_TIMER_PIN]  = timer_wave_output;
         next_p1_pad.oe_n[p2m_pkg::P2M_P1_TIMER_PIN] = 1'b0;
      end
   end

   // Pad outputs registered: one cycle later than the select, glitch free
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         p1_pad.out  <= p2m_pkg::P2M_RST_BYTE;
         p1_pad.oe_n <= ~p2m_pkg::P2M_RST_BYTE;
         p2_pad.out  <= p2m_pkg::P2M_RST_P2;
         p2_pad.oe_n <= ~p2m_pkg::P2M_RST_P2;
      end
      else
      begin
         p1_pad <= next_p1_pad;
         p2_pad <= next_p2_pad;
      end
   end

   // Alternate inputs toward the serial unit and interrupt logic
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         serial_rx_data <= 1'b1;
         serial_clk_in  <= 1'b0;
         irq_level_n    <= 4'hF;
      end
      else
      begin
         serial_rx_data <= serial_ctrl.rx_enable ? p2_in[p2m_pkg::P2M_P2_RX_PIN] : 1'b1;
         serial_clk_in  <= serial_ctrl.ext_clk_sel & p2_in[p2m_pkg::P2M_P2_CLK_PIN];
         irq_level_n    <= ~pin_mode_select_reg[7:4] | p1_in[7:4];
      end
   end

   // Checks
   chk_gpio_high_drive: assert property (@(posedge clk) disable iff (reset)
      (!tx_sel && port_direction_control[2]) |=> !p2_pad.oe_n[2])
      else $error("high pin not driven with direction bit set");
   chk_latch_drives: assert property (@(posedge clk) disable iff (reset)
      (!tx_sel && !serial_ctrl.rx_enable && port_direction_control[1])
      |=> p2_pad.out[1] == $past(port_output_data[1]))
      else $error("mid pin does not show latch");
   chk_read_data2: assert property (@(posedge clk) disable iff (reset)
      (rd && addr == p2m_pkg::P2M_OFF_DATA2) |=> rdata[2:0] ==
      (($past(port_direction_control) & $past(port_output_data))
       | (~$past(port_direction_control) & $past(p2_in))))
      else $error("data read mixes latch and pin wrongly");
   chk_read_ones: assert property (@(posedge clk) disable iff (reset)
      (rd && addr == p2m_pkg::P2M_OFF_DATA2) |=> rdata[7:3] == 5'h1F)
      else $error("upper data bits not read as one");
   chk_tx_override: assert property (@(posedge clk) disable iff (reset)
      tx_sel |=> !p2_pad.oe_n[2] && p2_pad.out[2] == $past(serial_tx_data))
      else $error("transmit pin not driven by serial unit");
   chk_rx_input: assert property (@(posedge clk) disable iff (reset)
      serial_ctrl.rx_enable |=> p2_pad.oe_n[1] && serial_rx_data == $past(p2_in[1]))
      else $error("receive pin not an input");
   chk_clk_input: assert property (@(posedge clk) disable iff (reset)
      serial_ctrl.ext_clk_sel |=> p2_pad.oe_n[0])
      else $error("clock pin driven while external clock");
   chk_clk_output: assert property (@(posedge clk) disable iff (reset)
      (!serial_ctrl.ext_clk_sel && clk_drive)
      |=> !p2_pad.oe_n[0] && p2_pad.out[0] == $past(serial_clk_out))
      else $error("clock pin not driving serial clock");
   chk_irq_input: assert property (@(posedge clk) disable iff (reset)
      pin_mode_select_reg[4] |=> p1_pad.oe_n[4])
      else $error("interrupt pin driven");
   chk_timer_output: assert property (@(posedge clk) disable iff (reset)
      pin_mode_select_reg[0] |=> !p1_pad.oe_n[0] && p1_pad.out[0] == $past(timer_wave_output))
      else $error("timer pin not driven by timer");
   chk_reset_values: assert property (@(posedge clk)
      reset |=> port_direction_control == 3'h0 && port_output_data == 3'h0 && !tx_sel)
      else $error("reset values wrong");

   // Register port answers
   chk_rdata_idle: assert property (@(posedge clk) disable iff (reset)
      !rd |=> rdata == 8'h00)
      else $error("read data not cleared after the read cycle");
   chk_dir_reads_ones: assert property (@(posedge clk) disable iff (reset)
      (rd && (addr == p2m_pkg::P2M_OFF_DIR1 || addr == p2m_pkg::P2M_OFF_DIR2))
      |=> rdata == 8'hFF)
      else $error("write-only direction register not read as all ones");
   chk_mode_read: assert property (@(posedge clk) disable iff (reset)
      (rd && addr == p2m_pkg::P2M_OFF_PIN_MODE)
      |=> rdata[3:2] == 2'h3 && rdata[1] == $past(tx_sel))
      else $error("pin mode read wrong");
   chk_read_data1: assert property (@(posedge clk) disable iff (reset)
      (rd && addr == p2m_pkg::P2M_OFF_DATA1) |=> rdata[3] && rdata[2:0] ==
      (($past(dir1[2:0]) & $past(data1[2:0])) | (~$past(dir1[2:0]) & $past(p1_in[2:0]))))
      else $error("port one read mixes latch and pin wrongly");

   // Port 2 general I/O when no alternate function claims the pin
   chk_high_gpio: assert property (@(posedge clk) disable iff (reset)
      !tx_sel |=> p2_pad.oe_n[2] == !$past(port_direction_control[2]))
      else $error("high pin direction not from direction bit");
   chk_mid_gpio: assert property (@(posedge clk) disable iff (reset)
      !serial_ctrl.rx_enable |=> p2_pad.oe_n[1] == !$past(port_direction_control[1]))
      else $error("mid pin direction not from direction bit");
   chk_low_gpio: assert property (@(posedge clk) disable iff (reset)
      (!serial_ctrl.ext_clk_sel && !clk_drive)
      |=> p2_pad.oe_n[0] == !$past(port_direction_control[0]))
      else $error("low pin direction not from direction bit");
   chk_high_latch: assert property (@(posedge clk) disable iff (reset)
      (!tx_sel && port_direction_control[2]) |=> p2_pad.out[2] == $past(port_output_data[2]))
      else $error("high pin does not show latch");
   chk_low_latch: assert property (@(posedge clk) disable iff (reset)
      (!serial_ctrl.ext_clk_sel && !clk_drive && port_direction_control[0])
      |=> p2_pad.out[0] == $past(port_output_data[0]))
      else $error("low pin does not show latch");

   // Inputs handed to the serial unit and interrupt logic
   chk_rx_idle: assert property (@(posedge clk) disable iff (reset)
      !serial_ctrl.rx_enable |=> serial_rx_data)
      else $error("receive input not idle while receiver off");
   chk_clk_sample: assert property (@(posedge clk) disable iff (reset)
      serial_ctrl.ext_clk_sel |=> serial_clk_in == $past(p2_in[0]))
      else $error("external clock not passed to serial unit");
   chk_clk_quiet: assert property (@(posedge clk) disable iff (reset)
      !serial_ctrl.ext_clk_sel |=> !serial_clk_in)
      else $error("clock input active without external clock");
   chk_irq_follow: assert property (@(posedge clk) disable iff (reset)
      pin_mode_select_reg[4] |=> irq_level_n[0] == $past(p1_in[4]))
      else $error("interrupt level does not follow its pin");
   chk_irq_masked: assert property (@(posedge clk) disable iff (reset)
      !pin_mode_select_reg[7] |=> irq_level_n[3])
      else $error("interrupt level active while not selected");

   // Port 1 pin functions
   chk_irq_pads: assert property (@(posedge clk) disable iff (reset)
      (pin_mode_select_reg[7:4] != 4'h0)
      |=> (p1_pad.oe_n[7:4] | ~$past(pin_mode_select_reg[7:4])) == 4'hF)
      else $error("selected interrupt pin driven");
   chk_absent_pin: assert property (@(posedge clk) disable iff (reset)
      p1_pad.oe_n[3])
      else $error("absent port one pin driven");
   chk_p1_gpio: assert property (@(posedge clk) disable iff (reset)
      1'h1 |=> p1_pad.oe_n[2:1] == ~$past(dir1[2:1]))
      else $error("plain port one pins not following direction");
   chk_p1_timer_off: assert property (@(posedge clk) disable iff (reset)
      !pin_mode_select_reg[0] |=> p1_pad.oe_n[0] == !$past(dir1[0]))
      else $error("timer pin direction not from direction bit");

   cov_tx_mode: cover property (@(posedge clk) disable iff (reset) tx_sel ##1 !p2_pad.oe_n[2]);
   cov_read_pin: cover property (@(posedge clk) disable iff (reset)
      rd && addr == p2m_pkg::P2M_OFF_DATA2 && port_direction_control == 3'h0);
   cov_clk_out: cover property (@(posedge clk) disable iff (reset)
      !serial_ctrl.ext_clk_sel && serial_ctrl.sync_mode);
   cov_ext_clk: cover property (@(posedge clk) disable iff (reset)
      serial_ctrl.ext_clk_sel ##1 p2_pad.oe_n[0]);
   cov_rx_read: cover property (@(posedge clk) disable iff (reset)
      serial_ctrl.rx_enable && rd && addr == p2m_pkg::P2M_OFF_DATA2);
endmodule

// ---- p2m_board.sv ----
// Board model for the two shared-pin ports: resolves each pin level.
// Assumes pad outputs are registered, so no loop forms through the pins.
`timescale 1ns/100ps
module p2m_board
(
   input  wire p2m_pkg::p2m_pad1_t p1_pad,
   input  wire p2m_pkg::p2m_pad2_t p2_pad,
   input  wire logic [7:0]         board1,
   input  wire logic [2:0]         board2,
   output logic      [7:0]         p1_in,
   output logic      [2:0]         p2_in
);
   // Undriven pins show a board value that changes every check in the random loop
   assign p1_in = (p1_pad.out & ~p1_pad.oe_n) | (board1 & p1_pad.oe_n);
   assign p2_in = (p2_pad.out & ~p2_pad.oe_n) | (board2 & p2_pad.oe_n);
endmodule

// ---- test_p2m_port_mux.sv ----
// Self-checking bench for the shared-pin port block, with a board model.
// Assumes a 100 MHz clock and the plain strobe register port.
`timescale 1ns/100ps
module test_p2m_port_mux;
   logic                      clk, reset, wr, rd, tx, clko, tmr;
   logic [2:0]                addr, p2_in, board2;
   logic [7:0]                wdata, rdata, p1_in, board1;
   logic [3:0]                irq_level_n;
   logic                      serial_rx_data, serial_clk_in;
   p2m_pkg::p2m_pad1_t        p1_pad;
   p2m_pkg::p2m_pad2_t        p2_pad;
   p2m_pkg::p2m_serial_ctrl_t sc;
   int                        err_total, comparisons, seed, pm, d1, q1, d2, q2;
   p2m_port_mux DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .p1_in(p1_in), .p1_pad(p1_pad), .p2_in(p2_in),
      .p2_pad(p2_pad), .serial_ctrl(sc), .serial_tx_data(tx), .serial_clk_out(clko),
      .serial_rx_data(serial_rx_data), .serial_clk_in(serial_clk_in),
      .timer_wave_output(tmr), .irq_level_n(irq_level_n));
   p2m_board board (.p1_pad(p1_pad), .p2_pad(p2_pad), .board1(board1), .board2(board2),
      .p1_in(p1_in), .p2_in(p2_in));
   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task automatic end_sim;
      if (err_total == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      case (a)
         3'h0: pm = d & 8'hF3;
         3'h1: d1 = d & 8'hF7;
         3'h2: q1 = d & 8'hF7;
         3'h3: d2 = d & 8'h07;
         3'h4: q2 = d & 8'h07;
         default: ;
      endcase
   endtask
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk("rdata", exp, rdata);
   endtask
   // Reference pin resolution: alternate functions win over direction
   task automatic check_all;
      int e1, v1, e2, v2, w1, w2;
      e2 = d2;
      v2 = q2;
      if (pm[1])
      begin
         e2 = e2 | 4;
         v2 = (v2 & 3) | (tx << 2);
      end
      if (sc.rx_enable)
         e2 = e2 & 5;
      if (sc.ext_clk_sel)
         e2 = e2 & 6;
      else if (sc.int_clk_out_sel || sc.sync_mode)
      begin
         e2 = e2 | 1;
         v2 = (v2 & 6) | clko;
      end
      e1 = d1 & ~(pm & 8'hF0) & 8'hF7;
      v1 = q1;
      if (pm[0])
      begin
         e1 = e1 | 1;
         v1 = (v1 & 8'hFE) | tmr;
      end
      w1 = (v1 & e1) | (board1 & ~e1);
      w2 = (v2 & e2) | (board2 & ~e2);
      chk("p2 oe_n", 8'(~e2 & 7), {5'h00, p2_pad.oe_n});
      chk("p2 out", 8'(v2 & e2), {5'h00, p2_pad.out & ~p2_pad.oe_n});
      chk("p1 oe_n", 8'(~e1 & 8'hFF), p1_pad.oe_n);
      chk("p1 out", 8'(v1 & e1), p1_pad.out & ~p1_pad.oe_n);
      chk("rx", {7'h00, sc.rx_enable ? w2[1] : 1'b1}, {7'h00, serial_rx_data});
      chk("clk in", {7'h00, sc.ext_clk_sel & w2[0]}, {7'h00, serial_clk_in});
      chk("irq", 8'((~pm | w1) >> 4 & 15), {4'h0, irq_level_n});
      rd_chk(3'h0, 8'((pm & 8'hF3) | 8'h0C));
      rd_chk(3'h1, 8'hFF);
      rd_chk(3'h2, 8'(8'h08 | (((d1 & q1) | (~d1 & w1)) & 8'hF7)));
      rd_chk(3'h3, 8'hFF);
      rd_chk(3'h4, 8'(8'hF8 | (((d2 & q2) | (~d2 & w2)) & 7)));
      rd_chk(3'(5 + ({$random(seed)} % 3)), 8'h00);
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      end_sim();
   end
   initial
   begin
      seed = 74640;
      {err_total, comparisons, pm, d1, q1, d2, q2} = '0;
      {reset, wr, rd, addr, wdata, sc, tx, clko, tmr} = '0;
      {board1, board2} = '0;
      reset = 1'b1;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check_all();
      repeat (300)
      begin
         @(posedge clk);
         sc <= 4'($random(seed));
         {tx, clko, tmr} <= 3'($random(seed));
         board1 <= 8'($random(seed));
         board2 <= 3'($random(seed));
         wr_reg(3'($random(seed)), 8'($random(seed)));
         repeat (3) @(posedge clk);
         @(negedge clk);
         check_all();
      end
      // Reset again from a busy state: every register must fall back
      @(posedge clk);
      reset <= 1'h1;
      repeat (5) @(posedge clk);
      reset <= 1'h0;
      {pm, d1, q1, d2, q2} = '0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check_all();
      end_sim();
   end
endmodule
